// ==== common/pvs_pkg.sv ====
// package for the input turn-off, sync mode and output overvoltage command bank
// assumes a command decoder upstream delivers whole command words on the core clock
package pvs_pkg;

    // ----------------------------------------------------------------
    // command codes
    // ----------------------------------------------------------------
    localparam logic [7:0]  CMD_INPUT_TURN_OFF   = 8'h36;
    localparam logic [7:0]  CMD_SYNC_MODE        = 8'h37;
    localparam logic [7:0]  CMD_OV_FAULT_LIMIT   = 8'h40;
    localparam logic [7:0]  CMD_OV_FAULT_ACTION  = 8'h41;
    localparam logic [7:0]  CMD_BANK_STATUS      = 8'h7e;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] RST_INPUT_TURN_OFF   = 16'hf812;
    localparam logic [15:0] RST_SYNC_MODE        = 16'h0100;
    localparam logic [15:0] RST_OV_FAULT_LIMIT   = 16'h0161;
    localparam logic [7:0]  RST_OV_FAULT_ACTION  = 8'hf8;

    // ----------------------------------------------------------------
    // turn-off threshold format and range, mantissa lsb is 0.5 V
    // ----------------------------------------------------------------
    localparam logic [4:0]  VIN_EXP_FIXED        = 5'h1f;
    localparam int          VIN_EXP_MSB          = 15;
    localparam int          VIN_EXP_LSB          = 11;
    localparam int          VIN_MAN_MSB          = 10;
    localparam logic [10:0] VIN_MAN_MIN          = 11'h002;
    localparam logic [10:0] VIN_MAN_MAX          = 11'h0a0;

    // ----------------------------------------------------------------
    // overvoltage limit range in 1.953 mV steps, 0.3 V to 14 V
    // ----------------------------------------------------------------
    localparam logic [15:0] OV_LIMIT_MIN         = 16'h009a;
    localparam logic [15:0] OV_LIMIT_MAX         = 16'h1c00;

    // ----------------------------------------------------------------
    // sync mode codes
    // ----------------------------------------------------------------
    localparam logic [15:0] MODE_STANDALONE      = 16'h0000;
    localparam logic [15:0] MODE_MASTER          = 16'h0100;
    localparam logic [15:0] MODE_SLAVE_IN_PHASE  = 16'h0120;
    localparam logic [15:0] MODE_SLAVE_OPPOSITE  = 16'h0121;

    // ----------------------------------------------------------------
    // overvoltage action byte fields
    // ----------------------------------------------------------------
    localparam int          OV_ACT_MSB           = 7;
    localparam int          OV_ACT_LSB           = 6;
    localparam logic [1:0]  OV_ACT_CONTINUE      = 2'h0;
    localparam logic [1:0]  OV_ACT_DISABLE       = 2'h3;

    // ----------------------------------------------------------------
    // status bits
    // ----------------------------------------------------------------
    localparam int          STAT_BAD_DATA        = 0;
    localparam int          STAT_OV_SEEN         = 1;
    localparam int          STAT_BAD_CODE        = 2;
    localparam int          STAT_W               = 3;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  code;
        logic [15:0] wdata;
    } pvs_cmd_s;

    typedef struct packed {
        logic        valid;
        logic        reject;
        logic [15:0] rdata;
    } pvs_rsp_s;

    typedef enum logic [1:0] {
        PWR_OFF     = 2'b00,
        PWR_RUN     = 2'b01,
        PWR_OV_HOLD = 2'b10
    } pvs_pwr_e;

endpackage : pvs_pkg

// ==== src/pvs_sync_in.sv ====
// two-stage synchroniser with rising edge detect for the sync pin
// assumes the pin is asynchronous to clock
`timescale 1ns/1ps
`default_nettype none
module pvs_sync_in
    import pvs_pkg::*;
(
    input  wire logic clock,
    input  wire logic nrst,
    input  wire logic pin_in,
    output logic      rise
);
    typedef struct packed {
        logic meta;
        logic stable;
        logic last;
        logic rise;
    } pvs_sin_s;

    pvs_sin_s s_q;
    pvs_sin_s s_d;

    // first stage feeds only the second stage
    always_comb
    begin
        s_d        = s_q;
        s_d.meta   = pin_in;
        s_d.stable = s_q.meta;
        s_d.last   = s_q.stable;
        s_d.rise   = s_q.stable & ~s_q.last;
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        // reset as idle high so a pulled-up pin gives no false edge
        if (!nrst)
            s_q <= '{1'b1, 1'b1, 1'b1, 1'b0};
        else
            s_q <= s_d;
    end

    assign rise = s_q.rise;
endmodule : pvs_sync_in
`default_nettype wire

// ==== src/pvs_phase_gen.sv ====
// switching phase counter with a 50% square and a phase pulse
// assumes period is given in clock cycles and changes slowly
`timescale 1ns/1ps
`default_nettype none
module pvs_phase_gen
    import pvs_pkg::*;
#(
    parameter int W = 16
)
(
    input  wire logic         clock,
    input  wire logic         nrst,
    input  wire logic [W-1:0] period,
    input  wire logic         load_zero,
    input  wire logic         load_half,
    output logic              phase_pulse,
    output logic              square
);
    localparam logic [W-1:0] ONE     = W'(1);
    localparam logic [W-1:0] MIN_PER = W'(2);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic         pulse;
        logic         sq;
    } pvs_ph_s;

    pvs_ph_s      s_q;
    pvs_ph_s      s_d;
    logic [W-1:0] per;

    always_comb
    begin
        // guard against a zero period stalling the counter
        per = (period < MIN_PER) ? MIN_PER : period;
        s_d = s_q;
        if (load_zero)
            s_d.cnt = '0;
        else if (load_half)
            s_d.cnt = per >> 1;
        else if (s_q.cnt >= per - ONE)
            s_d.cnt = '0;
        else
            s_d.cnt = s_q.cnt + ONE;
        s_d.pulse = (s_d.cnt == '0);
        s_d.sq    = (s_d.cnt < (per >> 1));
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign phase_pulse = s_q.pulse;
    assign square      = s_q.sq;
endmodule : pvs_phase_gen
`default_nettype wire

// ==== src/pvs_config_bank.sv ====
// command register bank: input turn-off, sync mode, output overvoltage limit and action
// assumes commands arrive decoded on clock; sense values come from logic on clock
//
// Behaviour
// - turn-off threshold accepts 1 V to 80 V in 0.5 V steps.
// - turn-off threshold resets to f812 meaning 9 V.
// - out-of-range or off-step threshold write is dropped and flagged.
// - sync mode register is read/write with four mode codes.
// - frequency comes from resistor until a frequency command replaces it.
// - master drives sync pin with in-phase 50% pulse once supply is good.
// - slave in-phase locks switching to external pulse at zero phase.
// - slave opposite locks switching to external pulse at 180 degrees.
// - sync mode resets to master; unknown mode codes are dropped and flagged.
// - 16-bit overvoltage limit; sensed output above it raises the fault.
// - limit covers 0.3 V to 14 V, resets to 0161.
// - action byte holds action, retry, delay fields; resets to f8.
// - action 00 keeps regulating through an overvoltage fault.
// - action 11 disables output while fault lasts, re-enables after.
// - default code retries forever until turned off, unbiased or other fault.
// - running conversion stops when input falls to the threshold.
// - threshold uses linear format with fixed exponent 11111.
`timescale 1ns/1ps
`default_nettype none
module pvs_config_bank
    import pvs_pkg::*;
#(
    parameter int PER_W = 16
)
(
    input  wire logic             clock,
    input  wire logic             nrst,
    input  wire pvs_cmd_s         cmd,
    output pvs_rsp_s              rsp,
    input  wire logic [10:0]      vin_sense,
    input  wire logic [15:0]      vout_sense,
    input  wire logic             enable_request,
    input  wire logic             vin_on_ok,
    input  wire logic             bias_ok,
    input  wire logic             other_fault,
    input  wire logic             vdd_above_uv,
    input  wire logic [PER_W-1:0] rt_period,
    input  wire logic             freq_cmd_valid,
    input  wire logic [PER_W-1:0] freq_cmd_period,
    input  wire logic             freq_set_sync_pin_i,
    output logic                  freq_set_sync_pin_o,
    output logic                  freq_set_sync_pin_oe_n,
    output logic                  conv_enable,
    output logic                  power_stage_enable,
    output logic                  ov_fault,
    output logic                  sw_pulse
);
    // ----------------------------------------------------------------
    // validation helpers
    // ----------------------------------------------------------------
    function automatic logic vin_ok(input logic [15:0] v);
        logic [10:0] man;
        man = v[VIN_MAN_MSB:0];
        // positive mantissa only; fixed exponent makes the 0.5 V step implicit
        vin_ok = (v[VIN_EXP_MSB:VIN_EXP_LSB] == VIN_EXP_FIXED)
               && (man >= VIN_MAN_MIN) && (man <= VIN_MAN_MAX);
    endfunction : vin_ok

    function automatic logic mode_ok(input logic [15:0] v);
        mode_ok = (v == MODE_STANDALONE) || (v == MODE_MASTER)
               || (v == MODE_SLAVE_IN_PHASE) || (v == MODE_SLAVE_OPPOSITE);
    endfunction : mode_ok

    function automatic logic action_ok(input logic [7:0] v);
        unique case (v)
            8'hf8, 8'h00, 8'h16, 8'h22, 8'h36,
            8'hc0, 8'hd6, 8'he2, 8'hf6: action_ok = 1'b1;
            default:                    action_ok = 1'b0;
        endcase
    endfunction : action_ok

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [15:0]      input_turn_off_threshold;
        logic [15:0]      mode;
        logic [15:0]      ov_limit;
        logic [7:0]       ov_action;
        logic [STAT_W-1:0] status;
        pvs_rsp_s         rsp;
        pvs_pwr_e         pwr;
        logic             ov;
        logic             freq_from_cmd;
        logic [PER_W-1:0] freq_period;
        logic             pin_o;
        logic             pin_oe_n;
    } pvs_bank_s;

    pvs_bank_s        s_q;
    pvs_bank_s        s_d;
    logic             sync_rise;
    logic             ph_pulse;
    logic             ph_square;
    logic [PER_W-1:0] period_sel;
    logic             slave_in;
    logic             slave_opp;
    logic             stop_req;
    logic             vin_low;
    logic [1:0]       act;

    // ----------------------------------------------------------------
    // sync pin input and phase generator
    // ----------------------------------------------------------------
    pvs_sync_in u_sync_in (
        .clock  (clock),
        .nrst   (nrst),
        .pin_in (freq_set_sync_pin_i),
        .rise   (sync_rise)
    );

    assign period_sel = s_q.freq_from_cmd ? s_q.freq_period : rt_period;
    assign slave_in   = (s_q.mode == MODE_SLAVE_IN_PHASE);
    assign slave_opp  = (s_q.mode == MODE_SLAVE_OPPOSITE);

    // edges outside the slave modes are ignored so a floating pin cannot pull phase
    pvs_phase_gen #(
        .W (PER_W)
    ) u_phase (
        .clock       (clock),
        .nrst        (nrst),
        .period      (period_sel),
        .load_zero   (sync_rise & slave_in),
        .load_half   (sync_rise & slave_opp),
        .phase_pulse (ph_pulse),
        .square      (ph_square)
    );

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    assign stop_req = ~enable_request | ~bias_ok | other_fault;
    assign vin_low  = (vin_sense <= s_q.input_turn_off_threshold[VIN_MAN_MSB:0]);
    assign act      = s_q.ov_action[OV_ACT_MSB:OV_ACT_LSB];

    always_comb
    begin
        s_d           = s_q;
        s_d.rsp       = '0;
        s_d.rsp.valid = cmd.valid;

        // frequency command overrides the resistor setting from then on
        if (freq_cmd_valid)
        begin
            s_d.freq_from_cmd = 1'b1;
            s_d.freq_period   = freq_cmd_period;
        end

        // sensed output above the limit is an overvoltage
        s_d.ov = (vout_sense > s_q.ov_limit);

        if (cmd.valid)
        begin
            unique case (cmd.code)
                CMD_INPUT_TURN_OFF:
                begin
                    s_d.rsp.rdata = s_q.input_turn_off_threshold;
                    if (cmd.write)
                    begin
                        if (vin_ok(cmd.wdata))
                            s_d.input_turn_off_threshold = cmd.wdata;
                        else
                        begin
                            s_d.rsp.reject              = 1'b1;
                            s_d.status[STAT_BAD_DATA]   = 1'b1;
                        end
                    end
                end
                CMD_SYNC_MODE:
                begin
                    s_d.rsp.rdata = s_q.mode;
                    if (cmd.write)
                    begin
                        if (mode_ok(cmd.wdata))
                            s_d.mode = cmd.wdata;
                        else
                        begin
                            s_d.rsp.reject              = 1'b1;
                            s_d.status[STAT_BAD_DATA]   = 1'b1;
                        end
                    end
                end
                CMD_OV_FAULT_LIMIT:
                begin
                    s_d.rsp.rdata = s_q.ov_limit;
                    if (cmd.write)
                    begin
                        if ((cmd.wdata >= OV_LIMIT_MIN) && (cmd.wdata <= OV_LIMIT_MAX))
                            s_d.ov_limit = cmd.wdata;
                        else
                        begin
                            s_d.rsp.reject              = 1'b1;
                            s_d.status[STAT_BAD_DATA]   = 1'b1;
                        end
                    end
                end
                CMD_OV_FAULT_ACTION:
                begin
                    s_d.rsp.rdata = {8'h00, s_q.ov_action};
                    if (cmd.write)
                    begin
                        // action byte is carried in the low data byte
                        if ((cmd.wdata[15:8] == 8'h00) && action_ok(cmd.wdata[7:0]))
                            s_d.ov_action = cmd.wdata[7:0];
                        else
                        begin
                            s_d.rsp.reject              = 1'b1;
                            s_d.status[STAT_BAD_DATA]   = 1'b1;
                        end
                    end
                end
                CMD_BANK_STATUS:
                begin
                    s_d.rsp.rdata = {13'h0000, s_q.status};
                    if (cmd.write)
                        s_d.status = s_q.status & ~cmd.wdata[STAT_W-1:0];
                end
                default:
                begin
                    s_d.rsp.reject            = 1'b1;
                    s_d.status[STAT_BAD_CODE] = 1'b1;
                end
            endcase
        end

        // hardware set applied after the clear so a same-cycle event is kept
        if (s_q.ov)
            s_d.status[STAT_OV_SEEN] = 1'b1;

        // power sequencing and overvoltage response
        unique case (s_q.pwr)
            PWR_OFF:
            begin
                if (!stop_req && vin_on_ok && !vin_low)
                    s_d.pwr = PWR_RUN;
            end
            PWR_RUN:
            begin
                if (stop_req || vin_low)
                    s_d.pwr = PWR_OFF;
                else if (s_q.ov && (act == OV_ACT_DISABLE))
                    s_d.pwr = PWR_OV_HOLD;
                // action 00 stays in run whatever retry and delay hold
            end
            PWR_OV_HOLD:
            begin
                // retries without limit until an outside stop ends it
                if (stop_req || vin_low)
                    s_d.pwr = PWR_OFF;
                else if (!s_q.ov || (act == OV_ACT_CONTINUE))
                    s_d.pwr = PWR_RUN;
            end
            default:
                s_d.pwr = PWR_OFF;
        endcase

        // master drives the pin once the internal supply is good
        if ((s_q.mode == MODE_MASTER) && vdd_above_uv)
        begin
            s_d.pin_oe_n = 1'b0;
            s_d.pin_o    = ph_square;
        end
        else
        begin
            s_d.pin_oe_n = 1'b1;
            s_d.pin_o    = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            s_q               <= '0;
            s_q.input_turn_off_threshold       <= RST_INPUT_TURN_OFF;
            s_q.mode          <= RST_SYNC_MODE;
            s_q.ov_limit      <= RST_OV_FAULT_LIMIT;
            s_q.ov_action     <= RST_OV_FAULT_ACTION;
            s_q.pwr           <= PWR_OFF;
            s_q.pin_oe_n      <= 1'b1;
        end
        else
            s_q <= s_d;
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign rsp                    = s_q.rsp;
    assign conv_enable            = (s_q.pwr != PWR_OFF);
    assign power_stage_enable     = (s_q.pwr == PWR_RUN);
    assign ov_fault               = s_q.ov;
    assign freq_set_sync_pin_o    = s_q.pin_o;
    assign freq_set_sync_pin_oe_n = s_q.pin_oe_n;
    assign sw_pulse               = ph_pulse;
endmodule : pvs_config_bank
`default_nettype wire

// ==== dv/pvs_checker.sv ====
// port assertions for the command bank
// assumes it is bound into pvs_config_bank on one clock
`timescale 1ns/1ps
`default_nettype none
module pvs_checker
    import pvs_pkg::*;
(
    input wire logic     clock,
    input wire logic     nrst,
    input wire pvs_cmd_s cmd,
    input wire pvs_rsp_s rsp,
    input wire logic     enable_request,
    input wire logic     bias_ok,
    input wire logic     other_fault,
    input wire logic     vdd_above_uv,
    input wire logic     freq_set_sync_pin_oe_n,
    input wire logic     conv_enable,
    input wire logic     power_stage_enable
);
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);

    logic [15:0] d;
    assign d = cmd.wdata;

    sequence wr_s(logic [7:0] c);
        cmd.valid && cmd.write && cmd.code == c;
    endsequence

    rsp_next_a: assert property (cmd.valid |=> rsp.valid)
        else $error("no response after command");
    rsp_quiet_a: assert property (!cmd.valid |=> !rsp.valid)
        else $error("response without command");
    mode_bad_a: assert property (wr_s(CMD_SYNC_MODE) ##0
        !(d inside {16'h0000, 16'h0100, 16'h0120, 16'h0121}) |=> rsp.reject) else $error("bad mode kept");
    mode_ok_a: assert property (wr_s(CMD_SYNC_MODE) ##0
        (d inside {16'h0000, 16'h0100, 16'h0120, 16'h0121}) |=> !rsp.reject) else $error("good mode refused");
    vin_bad_a: assert property (wr_s(CMD_INPUT_TURN_OFF) ##0 (d[15:11] != 5'h1f
        || d[10:0] < 11'h002 || d[10:0] > 11'h0a0) |=> rsp.reject) else $error("bad threshold kept");
    lim_bad_a: assert property (wr_s(CMD_OV_FAULT_LIMIT) ##0
        (d < 16'h009a || d > 16'h1c00) |=> rsp.reject) else $error("bad limit kept");
    act_bad_a: assert property (wr_s(CMD_OV_FAULT_ACTION) ##0 !(d inside {16'h00f8, 16'h0000,
        16'h0016, 16'h0022, 16'h0036, 16'h00c0, 16'h00d6, 16'h00e2, 16'h00f6}) |=> rsp.reject)
        else $error("bad action kept");
    stop_off_a: assert property (power_stage_enable && (!enable_request || !bias_ok
        || other_fault) |=> !conv_enable) else $error("no stop on turn off");
    drive_uv_a: assert property (!freq_set_sync_pin_oe_n |-> $past(vdd_above_uv))
        else $error("sync driven below supply level");
endmodule : pvs_checker

bind pvs_config_bank pvs_checker i_pvs_checker (
    .clock(clock), .nrst(nrst), .cmd(cmd), .rsp(rsp),
    .enable_request(enable_request), .bias_ok(bias_ok), .other_fault(other_fault),
    .vdd_above_uv(vdd_above_uv), .freq_set_sync_pin_oe_n(freq_set_sync_pin_oe_n),
    .conv_enable(conv_enable), .power_stage_enable(power_stage_enable)
);
`default_nettype wire

// ==== dv/pvs_sync_src.sv ====
// another regulator acting as sync source on the shared sync pin
// assumes period in clock cycles; a released pin reads high
`timescale 1ns/1ps
`default_nettype none
module pvs_sync_src #(
    parameter int PER = 12
)
(
    input  wire logic clock,
    input  wire logic en,
    output logic      level
);
    int cnt = 0;

    always @(posedge clock)
    begin
        cnt <= (cnt + 1) % PER;
    end

    // pull-up holds the line when nobody drives
    assign level = en ? (cnt < PER / 2) : 1'b1;
endmodule : pvs_sync_src
`default_nettype wire

// ==== dv/tb_top.sv ====
// self-checking bench for the command bank
// assumes a 40 MHz clock and inputs driven on the falling edge
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import pvs_pkg::*;
;
    logic        clock = 0, nrst = 0, en_rq = 0, von = 0, bias = 0, ofl = 0;
    logic        vdd = 0, fcv = 0, src_en = 0;
    logic [10:0] vin = '0;
    logic [15:0] vout = '0, rt = 16'h0010, fcp = 16'h000c;
    logic        pin_i, pin_o, oe_n, conv, pse, ovf, swp, src_lvl;
    logic [4:0]  mon;
    pvs_cmd_s    cmd_r = '0;
    pvs_rsp_s    rsp_w;
    int          err_count = 0, samples_checked = 0;
    logic [7:0]  acts [9] = '{8'hf8, 8'h00, 8'h16, 8'h22, 8'h36, 8'hc0, 8'hd6, 8'he2, 8'hf6};
    logic [15:0] modes [4] = '{16'h0000, 16'h0100, 16'h0120, 16'h0121};

    assign pin_i = !oe_n ? pin_o : src_lvl;
    assign mon = {src_lvl, swp, ovf, pse, conv};

    pvs_config_bank #(.PER_W(16)) i_pvs_config_bank (
        .clock(clock), .nrst(nrst), .cmd(cmd_r), .rsp(rsp_w), .vin_sense(vin), .vout_sense(vout),
        .enable_request(en_rq), .vin_on_ok(von), .bias_ok(bias), .other_fault(ofl),
        .vdd_above_uv(vdd), .rt_period(rt), .freq_cmd_valid(fcv), .freq_cmd_period(fcp),
        .freq_set_sync_pin_i(pin_i), .freq_set_sync_pin_o(pin_o), .freq_set_sync_pin_oe_n(oe_n),
        .conv_enable(conv), .power_stage_enable(pse), .ov_fault(ovf), .sw_pulse(swp)
    );
    pvs_sync_src #(.PER(12)) i_pvs_sync_src (.clock(clock), .en(src_en), .level(src_lvl));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic summarize;
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize

    task automatic chk(input string nm, input logic [17:0] e, input logic [17:0] g);
        samples_checked++;
        if (g !== e)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // one command, answer judged the cycle after it is taken
    task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                        input logic rj, input logic [15:0] rd);
        @(negedge clock);
        cmd_r = '{1'b1, w, c, d};
        @(negedge clock);
        cmd_r.valid = 1'b0;
        chk("response", {1'b1, rj, w ? 16'h0 : rd}, {rsp_w.valid, rsp_w.reject, w ? 16'h0 : rsp_w.rdata});
    endtask : xfer

    task automatic wt(input int i, input logic v, output int n);
        for (n = 0; mon[i] !== v; n++)
        begin
            if (n == 400)
            begin
                err_count++;
                summarize();
            end
            @(negedge clock);
        end
    endtask : wt

    task automatic gap(output int g);
        int a;
        wt(3, 1, a);
        wt(3, 0, a);
        wt(3, 1, g);
        g += a;
    endtask : gap

    task automatic lag(output int l);
        int a;
        wt(4, 0, a);
        wt(4, 1, a);
        wt(3, 1, l);
    endtask : lag

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        xfer(0, CMD_INPUT_TURN_OFF, 0, 0, 16'hf812);
        xfer(0, CMD_SYNC_MODE, 0, 0, 16'h0100);
        xfer(0, CMD_OV_FAULT_LIMIT, 0, 0, 16'h0161);
        xfer(0, CMD_OV_FAULT_ACTION, 0, 0, 16'h00f8);
    endtask : t_reset

    task automatic t_thresh;
        xfer(1, CMD_INPUT_TURN_OFF, 16'hf802, 0, 0);
        xfer(1, CMD_INPUT_TURN_OFF, 16'hf8a0, 0, 0);
        xfer(1, CMD_INPUT_TURN_OFF, 16'hf801, 1, 0);
        xfer(1, CMD_INPUT_TURN_OFF, 16'hf8a1, 1, 0);
        xfer(1, CMD_INPUT_TURN_OFF, 16'h00a0, 1, 0);
        xfer(0, CMD_INPUT_TURN_OFF, 0, 0, 16'hf8a0);
    endtask : t_thresh

    task automatic t_limit;
        xfer(1, CMD_OV_FAULT_LIMIT, 16'h009a, 0, 0);
        xfer(1, CMD_OV_FAULT_LIMIT, 16'h0099, 1, 0);
        xfer(1, CMD_OV_FAULT_LIMIT, 16'h1c01, 1, 0);
        xfer(1, CMD_OV_FAULT_LIMIT, 16'h1c00, 0, 0);
        xfer(0, CMD_OV_FAULT_LIMIT, 0, 0, 16'h1c00);
        foreach (acts[k])
            xfer(1, CMD_OV_FAULT_ACTION, {8'h00, acts[k]}, 0, 0);
        xfer(1, CMD_OV_FAULT_ACTION, 16'h00f9, 1, 0);
        xfer(1, CMD_OV_FAULT_ACTION, 16'h01f8, 1, 0);
        xfer(0, CMD_OV_FAULT_ACTION, 0, 0, 16'h00f6);
    endtask : t_limit

    task automatic t_modes;
        foreach (modes[k])
        begin
            xfer(1, CMD_SYNC_MODE, modes[k], 0, 0);
            xfer(0, CMD_SYNC_MODE, 0, 0, modes[k]);
        end
        xfer(1, CMD_SYNC_MODE, 16'h0101, 1, 0);
        xfer(0, CMD_SYNC_MODE, 0, 0, 16'h0121);
        xfer(1, 8'h55, 16'h0000, 1, 0);
        xfer(0, CMD_BANK_STATUS, 0, 0, 16'h0005);
        xfer(1, CMD_BANK_STATUS, 16'h0007, 0, 0);
        xfer(0, CMD_BANK_STATUS, 0, 0, 16'h0000);
    endtask : t_modes

    task automatic t_power;
        int n;
        xfer(1, CMD_INPUT_TURN_OFF, 16'hf812, 0, 0);
        xfer(1, CMD_OV_FAULT_LIMIT, 16'h0200, 0, 0);
        xfer(1, CMD_OV_FAULT_ACTION, 16'h0000, 0, 0);
        vin = 11'd20;
        vout = 16'h0100;
        en_rq = 1;
        von = 1;
        bias = 1;
        wt(1, 1, n);
        vout = 16'h0201;
        wt(2, 1, n);
        chk("fault delay", 1, n);
        repeat (3) @(negedge clock);
        chk("stage on", 1, pse);
        vout = 16'h0100;
        xfer(1, CMD_OV_FAULT_ACTION, 16'h00c0, 0, 0);
        vout = 16'h0201;
        wt(1, 0, n);
        chk("conv kept", 1, conv);
        vout = 16'h0100;
        wt(1, 1, n);
        xfer(1, CMD_OV_FAULT_ACTION, 16'h00f8, 0, 0);
        en_rq = 0;
        wt(0, 0, n);
        chk("stop delay", 1, n < 3);
        en_rq = 1;
        wt(1, 1, n);
        vin = 11'd18;
        wt(0, 0, n);
        chk("low input", 1, n < 3);
        vin = 11'd20;
    endtask : t_power

    task automatic t_sync;
        int a, l1, l2;
        xfer(1, CMD_SYNC_MODE, 16'h0000, 0, 0);
        gap(a);
        gap(a);
        chk("resistor period", 16, a);
        chk("standalone pin", 1, oe_n);
        fcv = 1;
        @(negedge clock);
        fcv = 0;
        gap(a);
        gap(a);
        chk("command period", 12, a);
        vdd = 1;
        xfer(1, CMD_SYNC_MODE, 16'h0100, 0, 0);
        repeat (3) @(negedge clock);
        chk("master drive", 0, oe_n);
        a = 0;
        repeat (24)
        begin
            @(negedge clock);
            a += pin_o;
        end
        chk("sync duty", 12, a);
        xfer(1, CMD_SYNC_MODE, 16'h0120, 0, 0);
        src_en = 1;
        lag(l1);
        lag(l1);
        lag(l2);
        chk("lock lag", 4, l1);
        chk("in phase lag", l1, l2);
        chk("slave pin", 1, oe_n);
        xfer(1, CMD_SYNC_MODE, 16'h0121, 0, 0);
        lag(l2);
        lag(l2);
        chk("opposite lag", (l1 + 6) % 12, l2);
    endtask : t_sync

    initial
    begin
        forever #12.5 clock = ~clock;
    end

    initial
    begin
        repeat (10) @(negedge clock);
        nrst = 1;
        t_reset();
        t_thresh();
        t_limit();
        t_modes();
        t_power();
        t_sync();
        summarize();
    end
endmodule : tb_top
`default_nettype wire
